//--- hdl/phyc_consts.vh
`ifndef PHYC_CONSTS_VH
`define PHYC_CONSTS_VH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define PHYC_IDX_CONTROL      6'h19
`define PHYC_IDX_ERRCOUNT     6'h1B
`define PHYC_ADDR_CONTROL     ({`PHYC_IDX_CONTROL, 2'b00})
`define PHYC_ADDR_ERRCOUNT    ({`PHYC_IDX_ERRCOUNT, 2'b00})
`define PHYC_ADDR_HI_ZERO     24'h000000

// ----------------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------------
`define PHYC_BIT_AUTOX        15
`define PHYC_BIT_FORCEX       14
`define PHYC_BIT_PAUSE_RX     13
`define PHYC_BIT_PAUSE_TX     12
`define PHYC_BIT_INJECT       11
`define PHYC_BIT_SEQ15        10
`define PHYC_BIT_PASS         9
`define PHYC_BIT_RUN          8
`define PHYC_BIT_BYPASS       7
`define PHYC_BIT_LED1         6
`define PHYC_BIT_LED0         5
`define PHYC_ADDR_MSB         4
`define PHYC_ADDR_LSB         0

// advertised pause field: bit 0 symmetric pause, bit 1 asymmetric direction
`define PHYC_PAUSE_SYM        0
`define PHYC_PAUSE_ASYM       1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PHYC_RST_BIT          1'b0
`define PHYC_RST_LED1         1'b0
`define PHYC_RST_WORD         32'h00000000
`define PHYC_RST_COUNT        8'h00

// ----------------------------------------------------------------------
// timing and self-test constants
// ----------------------------------------------------------------------
`define PHYC_STRETCH_CYCLES   12'hFFF
`define PHYC_CNT_ZERO         12'h000
`define PHYC_CNT_ONE          12'h001
`define PHYC_BLINK_MSB        11
`define PHYC_LFSR_SEED        15'h7FFF
`define PHYC_CHK_CLEAR        15'h0000
`define PHYC_SYNC_LEN15       4'hF
`define PHYC_SYNC_LEN9        4'h9
`define PHYC_SYNC_ZERO        4'h0
`define PHYC_SYNC_ONE         4'h1
`define PHYC_COUNT_MAX        8'hFF
`define PHYC_COUNT_ONE        8'h01

`endif

//--- hdl/phyc_selftest.v
`timescale 1ns/1ps
`include "phyc_consts.vh"

module phyc_selftest (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       ce,
  input  wire       run,
  input  wire       seq15,
  input  wire       inject,
  input  wire       rx_bit,
  output reg        tx_bit,
  output reg        err,
  output reg  [7:0] err_count
);

  reg  [14:0] gen;
  reg  [14:0] chk;
  reg  [3:0]  sync_cnt;
  reg         run_d;
  wire        gen_fb  = seq15 ? (gen[14] ^ gen[13]) : (gen[8] ^ gen[4]);
  wire        chk_fb  = seq15 ? (chk[14] ^ chk[13]) : (chk[8] ^ chk[4]);
  wire        live    = seq15 ? (|chk) : (|chk[8:0]);
  wire [3:0]  sync_len = seq15 ? `PHYC_SYNC_LEN15 : `PHYC_SYNC_LEN9;
  wire        synced  = (sync_cnt == sync_len);
  wire        start   = run & ~run_d;
  wire        mismatch = run & synced & (rx_bit != chk_fb);

  // ----------------------------------------------------------------------
  // generator and checker
  // ----------------------------------------------------------------------
  // the checker follows the line until a non-zero window has predicted a full
  // state of bits in a row, so idle bits ahead of the sequence and any line
  // delay cannot lock it wrongly; then it runs on its own so that one flipped
  // bit is counted once and not per tap
  always @(posedge sys_clk) begin
    if (!nrst) begin
      gen       <= `PHYC_LFSR_SEED;
      chk       <= `PHYC_LFSR_SEED;
      sync_cnt  <= `PHYC_SYNC_ZERO;
      run_d     <= `PHYC_RST_BIT;
      tx_bit    <= `PHYC_RST_BIT;
      err       <= `PHYC_RST_BIT;
      err_count <= `PHYC_RST_COUNT;
    end else if (ce) begin
      run_d <= run;
      err   <= mismatch;
      if (start) begin
        gen       <= `PHYC_LFSR_SEED;
        chk       <= `PHYC_CHK_CLEAR;
        sync_cnt  <= `PHYC_SYNC_ZERO;
        err_count <= `PHYC_RST_COUNT;
      end else if (run) begin
        gen    <= {gen[13:0], gen_fb};
        tx_bit <= gen_fb ^ inject;
        if (!synced) begin
          chk <= {chk[13:0], rx_bit};
          if (live && (rx_bit == chk_fb))
            sync_cnt <= sync_cnt + `PHYC_SYNC_ONE;
          else
            sync_cnt <= `PHYC_SYNC_ZERO;
        end else begin
          chk <= {chk[13:0], chk_fb};
        end
        if (mismatch && err_count != `PHYC_COUNT_MAX)
          err_count <= err_count + `PHYC_COUNT_ONE;
      end else begin
        tx_bit <= `PHYC_RST_BIT;
      end
    end
  end

endmodule // phyc_selftest

//--- hdl/phyc_top.v
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "phyc_consts.vh"


module phyc_top (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        strap_auto_crossover,
  input  wire        strap_led_mode0,
  input  wire [4:0]  strap_port_address,
  input  wire        autoneg_enable,
  input  wire        crossover_detect,
  input  wire [1:0]  local_pause_adv,
  input  wire [1:0]  partner_pause_adv,
  input  wire        full_duplex_hcd,
  input  wire        link_good,
  input  wire        speed_100,
  input  wire        activity,
  input  wire        collision,
  input  wire        duplex_full,
  input  wire        selftest_rx_bit,
  output reg         pair_swap,
  output reg         pause_rx_enable,
  output reg         pause_tx_enable,
  output reg         link_indicator,
  output reg         speed_indicator,
  output reg         activity_collision_indicator,
  output wire        selftest_tx_bit,
  output reg  [4:0]  port_address
);

  reg        auto_crossover_enable;
  reg        crossover_force;
  reg        selftest_error_inject;
  reg        selftest_sequence_select;
  reg        selftest_run;
  reg        selftest_fail;
  reg        led_stretch_bypass;
  reg  [1:0] led_mode_select;
  reg        wr_pend;
  reg        rd_pend;
  reg        rd_done;
  reg  [7:0] a_addr;
  reg  [11:0] blink_cnt;
  wire       st_err;
  wire [7:0] st_count;
  wire [1:0] led_raw = {collision, activity};
  wire [1:0] led_str;

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  // reads take one wait state so a read right after a write sees the new value;
  // a low ce stalls the bus rather than letting a transfer slip past frozen state
  wire       ready_int = ~rd_pend | rd_done;
  assign hreadyout = ce & ready_int;
  assign hresp     = 1'b0;
  wire       accept  = hsel & htrans[1] & hready & ce;
  wire       do_wr   = ce & wr_pend;
  wire       hit_ctl = (a_addr == `PHYC_ADDR_CONTROL);
  wire       hit_cnt = (a_addr == `PHYC_ADDR_ERRCOUNT);

  wire        selftest_pass_flag = selftest_run & ~selftest_fail;
  wire [15:0] ctl_word = {auto_crossover_enable, crossover_force, pause_rx_enable,
                          pause_tx_enable, selftest_error_inject, selftest_sequence_select,
                          selftest_pass_flag, selftest_run, led_stretch_bypass,
                          led_mode_select, port_address};

  always @(posedge sys_clk) begin
    if (!nrst) begin
      wr_pend <= `PHYC_RST_BIT;
      rd_pend <= `PHYC_RST_BIT;
      rd_done <= `PHYC_RST_BIT;
      a_addr  <= 8'h00;
      hrdata  <= `PHYC_RST_WORD;
    end else if (ce) begin
      if (ready_int) begin
        wr_pend <= accept & hwrite;
        rd_pend <= accept & ~hwrite;
        rd_done <= `PHYC_RST_BIT;
        if (accept)
          a_addr <= (haddr[31:8] == `PHYC_ADDR_HI_ZERO) ? haddr[7:0] : 8'hFF;
      end else begin
        rd_done <= 1'b1;
        if (hit_ctl)
          hrdata <= {16'h0000, ctl_word};
        else if (hit_cnt)
          hrdata <= {24'h000000, st_count};
        else
          hrdata <= `PHYC_RST_WORD;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  // strap levels are sampled while reset is held, since the reset is synchronous
  always @(posedge sys_clk) begin
    if (!nrst) begin
      auto_crossover_enable    <= strap_auto_crossover;
      crossover_force          <= `PHYC_RST_BIT;
      selftest_error_inject    <= `PHYC_RST_BIT;
      selftest_sequence_select <= `PHYC_RST_BIT;
      selftest_run             <= `PHYC_RST_BIT;
      led_stretch_bypass       <= `PHYC_RST_BIT;
      led_mode_select          <= {`PHYC_RST_LED1, strap_led_mode0};
      port_address             <= strap_port_address;
    end else if (ce) begin
      selftest_error_inject <= `PHYC_RST_BIT;
      if (do_wr && hit_ctl) begin
        auto_crossover_enable    <= hwdata[`PHYC_BIT_AUTOX];
        crossover_force          <= hwdata[`PHYC_BIT_FORCEX];
        selftest_error_inject    <= hwdata[`PHYC_BIT_INJECT];
        selftest_sequence_select <= hwdata[`PHYC_BIT_SEQ15];
        selftest_run             <= hwdata[`PHYC_BIT_RUN];
        led_stretch_bypass       <= hwdata[`PHYC_BIT_BYPASS];
        led_mode_select          <= {hwdata[`PHYC_BIT_LED1], hwdata[`PHYC_BIT_LED0]};
        port_address             <= hwdata[`PHYC_ADDR_MSB:`PHYC_ADDR_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // pause resolution, crossover and self-test status
  // ----------------------------------------------------------------------
  wire lp = local_pause_adv[`PHYC_PAUSE_SYM];
  wire la = local_pause_adv[`PHYC_PAUSE_ASYM];
  wire pp = partner_pause_adv[`PHYC_PAUSE_SYM];
  wire pa = partner_pause_adv[`PHYC_PAUSE_ASYM];

  always @(posedge sys_clk) begin
    if (!nrst) begin
      pause_rx_enable <= `PHYC_RST_BIT;
      pause_tx_enable <= `PHYC_RST_BIT;
      pair_swap       <= `PHYC_RST_BIT;
      selftest_fail   <= `PHYC_RST_BIT;
    end else if (ce) begin
      pause_rx_enable <= full_duplex_hcd & ((lp & pp) | (lp & la & ~pp & pa));
      pause_tx_enable <= full_duplex_hcd & ((lp & pp) | (~lp & la & pp & pa));
      // the automatic decision is honoured only while auto-negotiation runs
      pair_swap <= crossover_force |
                   (auto_crossover_enable & autoneg_enable & crossover_detect);
      // an error in the stop cycle still latches; it is released on the next idle cycle
      if (st_err)
        selftest_fail <= 1'b1;
      else if (!selftest_run)
        selftest_fail <= `PHYC_RST_BIT;
    end
  end

  phyc_selftest i_phyc_selftest (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .ce        (ce),
    .run       (selftest_run),
    .seq15     (selftest_sequence_select),
    .inject    (selftest_error_inject),
    .rx_bit    (selftest_rx_bit),
    .tx_bit    (selftest_tx_bit),
    .err       (st_err),
    .err_count (st_count)
  );

  // ----------------------------------------------------------------------
  // led stretching and mode selection
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_stretch
      reg [11:0] cnt;
      always @(posedge sys_clk) begin
        if (!nrst)
          cnt <= `PHYC_CNT_ZERO;
        else if (ce) begin
          if (led_raw[i])
            cnt <= `PHYC_STRETCH_CYCLES;
          else if (cnt != `PHYC_CNT_ZERO)
            cnt <= cnt - `PHYC_CNT_ONE;
        end
      end
      // short events would be invisible on an LED without the hold time
      assign led_str[i] = led_stretch_bypass ? led_raw[i] :
                          (led_raw[i] | (cnt != `PHYC_CNT_ZERO));
    end
  endgenerate

  wire blink_off = led_str[0] & blink_cnt[`PHYC_BLINK_MSB];

  always @(posedge sys_clk) begin
    if (!nrst) begin
      blink_cnt                    <= `PHYC_CNT_ZERO;
      link_indicator               <= `PHYC_RST_BIT;
      speed_indicator              <= `PHYC_RST_BIT;
      activity_collision_indicator <= `PHYC_RST_BIT;
    end else if (ce) begin
      blink_cnt       <= blink_cnt + `PHYC_CNT_ONE;
      speed_indicator <= speed_100;
      if (led_mode_select[0]) begin
        link_indicator               <= link_good;
        activity_collision_indicator <= led_str[0];
      end else if (!led_mode_select[1]) begin
        link_indicator               <= link_good & ~blink_off;
        activity_collision_indicator <= led_str[1];
      end else begin
        link_indicator               <= link_good & ~blink_off;
        activity_collision_indicator <= duplex_full;
      end
    end
  end

endmodule // phyc_top

//--- tb/phyc_line_model.sv
`timescale 1ns/1ps

module phyc_line_model (
  input  wire sys_clk,
  input  wire tx_bit,
  output reg  rx_bit
);
  // cable loopback with one cycle of line delay; never corrupts on its own
  initial rx_bit = 1'b0;
  always @(posedge sys_clk) begin
    rx_bit <= tx_bit;
  end
endmodule // phyc_line_model

//--- tb/phyc_checker_asserts.sv
`timescale 1ns/1ps

module phyc_checker (
  input wire       sys_clk, nrst, ce, hsel, hwrite, hready, hreadyout, hresp,
  input wire [1:0] htrans, local_pause_adv, partner_pause_adv,
  input wire       full_duplex_hcd, pause_rx_enable, pause_tx_enable,
  input wire       speed_100, speed_indicator, link_good, link_indicator,
  input wire [4:0] strap_port_address, port_address
);
  wire ls = local_pause_adv[0];
  wire la = local_pause_adv[1];
  wire ps = partner_pause_adv[0];
  wire pa = partner_pause_adv[1];
  wire rx_exp = full_duplex_hcd & ((ls & ps) | (ls & la & ~ps & pa));
  wire tx_exp = full_duplex_hcd & ((ls & ps) | (~ls & la & ps & pa));
  wire taken = hsel & htrans[1] & hready & ce;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_OKAY: assert property (hresp == 1'b0) else $error("bus response not okay");
  AST_PAUSE_RX: assert property ($past(ce) && $past(nrst) |->
    pause_rx_enable == $past(rx_exp)) else $error("pause receive mismatch");
  AST_PAUSE_TX: assert property ($past(ce) && $past(nrst) |->
    pause_tx_enable == $past(tx_exp)) else $error("pause transmit mismatch");
  AST_READ_WAIT: assert property (taken && !hwrite |=> !hreadyout ##1 (hreadyout || !ce))
    else $error("read wait state wrong");
  AST_WRITE_ZW: assert property (taken && hwrite |=> hreadyout || !ce)
    else $error("write stalled");
  AST_STRAP_ADDR: assert property ($rose(nrst) && $past(ce) |->
    port_address == $past(strap_port_address)) else $error("port address not from strap");
  AST_SPEED: assert property ($past(ce) && $past(nrst) |->
    speed_indicator == $past(speed_100)) else $error("speed indicator wrong");
  AST_LINK: assert property ($past(ce) && $past(nrst) && !$past(link_good) |->
    !link_indicator) else $error("link indicator on without link");
endmodule // phyc_checker

bind phyc_top phyc_checker i_phyc_checker (
  .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .hsel(hsel), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans), .local_pause_adv(local_pause_adv),
  .partner_pause_adv(partner_pause_adv), .full_duplex_hcd(full_duplex_hcd),
  .pause_rx_enable(pause_rx_enable), .pause_tx_enable(pause_tx_enable),
  .speed_100(speed_100), .speed_indicator(speed_indicator), .link_good(link_good),
  .link_indicator(link_indicator), .strap_port_address(strap_port_address),
  .port_address(port_address)
);

//--- tb/test_phy_control_register.sv
`timescale 1ns/1ps
`include "phyc_consts.vh"

module test_phy_control_register;
  localparam logic [31:0] A_CTL = 32'(`PHYC_ADDR_CONTROL);
  localparam logic [31:0] A_CNT = 32'(`PHYC_ADDR_ERRCOUNT);
  localparam logic [31:0] A_BAD = 32'h00000068;
  logic        sys_clk, nrst, ce, hsel, hwrite, aneg, xdet, fd, link, spd, act, col, dup;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans, lpa, ppa;
  wire         hreadyout, hresp, swap, prx, ptx, led_l, led_s, led_a, st_tx, st_rx;
  wire  [31:0] hrdata;
  wire  [4:0]  paddr;
  logic [31:0] mctl [3] = '{32'h000000A0, 32'h00000080, 32'h000000C0};
  int          errors, compares;

  phyc_top i_phyc_top (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .strap_auto_crossover(1'b1),
    .strap_led_mode0(1'b1), .strap_port_address(5'h15), .autoneg_enable(aneg),
    .crossover_detect(xdet), .local_pause_adv(lpa), .partner_pause_adv(ppa),
    .full_duplex_hcd(fd), .link_good(link), .speed_100(spd), .activity(act),
    .collision(col), .duplex_full(dup), .selftest_rx_bit(st_rx), .pair_swap(swap),
    .pause_rx_enable(prx), .pause_tx_enable(ptx), .link_indicator(led_l),
    .speed_indicator(led_s), .activity_collision_indicator(led_a),
    .selftest_tx_bit(st_tx), .port_address(paddr)
  );
  phyc_line_model i_phyc_line_model (.sys_clk(sys_clk), .tx_bit(st_tx), .rx_bit(st_rx));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        $display("CHECK FAILED hready expected 1 seen timeout");
        summarize();
      end
      @(posedge sys_clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(name, exp, q);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  initial begin
    int i;
    int m;
    int v;
    int n;
    {nrst, hsel, hwrite, fd, link, spd, act, col, dup, xdet} = '0;
    {haddr, hwdata, htrans, lpa, ppa} = '0;
    ce = 1'b1;
    aneg = 1'b1;
    errors = 0;
    compares = 0;
    settle(3);
    nrst <= 1'b1;
    rd_chk("ctl reset", A_CTL, 32'h00008035);
    check("port address reset", 32'h15, 32'(paddr));
    xdet <= 1'b1;
    settle(3);
    check("auto crossover", 32'h1, 32'(swap));
    $display("test reset done");
    bus(1'b1, A_CTL, 32'hFFFFF0EA);
    rd_chk("ctl readback", A_CTL, 32'h0000C0EA);
    check("port address", 32'h0A, 32'(paddr));
    check("pair swap forced", 32'h1, 32'(swap));
    bus(1'b1, A_BAD, 32'h00000000);
    rd_chk("unmapped read", A_BAD, 32'h00000000);
    rd_chk("ctl after unmapped", A_CTL, 32'h0000C0EA);
    $display("test access done");
    for (i = 0; i < 32; i++) begin
      {fd, lpa, ppa} <= i[4:0];
      settle(2);
      check("pause rx", 32'(fd & ((lpa[0] & ppa[0]) | (&lpa & ~ppa[0] & ppa[1]))), 32'(prx));
      check("pause tx", 32'(fd & ((lpa[0] & ppa[0]) | (~lpa[0] & lpa[1] & &ppa))), 32'(ptx));
    end
    {fd, lpa, ppa} <= 5'h15;
    rd_chk("ctl pause bits", A_CTL, 32'h0000F0EA);
    $display("test pause done");
    bus(1'b1, A_CTL, 32'h00000500);
    settle(60);
    rd_chk("selftest pass", A_CTL, 32'h00003700);
    check("crossover off", 32'h0, 32'(swap));
    bus(1'b1, A_CTL, 32'h00000D00);
    settle(20);
    rd_chk("selftest fail", A_CTL, 32'h00003500);
    rd_chk("error count", A_CNT, 32'h00000001);
    bus(1'b1, A_CTL, 32'h00000000);
    rd_chk("selftest stop", A_CTL, 32'h00003000);
    bus(1'b1, A_CTL, 32'h00000100);
    settle(40);
    rd_chk("selftest nine", A_CTL, 32'h00003300);
    rd_chk("count cleared", A_CNT, 32'h00000000);
    $display("test selftest done");
    link <= 1'b1;
    for (m = 0; m < 3; m++) begin
      bus(1'b1, A_CTL, mctl[m]);
      for (v = 0; v < 2; v++) begin
        act <= (m == 0) ? v[0] : 1'b0;
        col <= (m == 1) ? v[0] : !v[0];
        dup <= (m == 2) ? v[0] : !v[0];
        spd <= v[0];
        settle(3);
        check("third led", 32'(v), 32'(led_a));
        check("speed led", 32'(v), 32'(led_s));
        check("link led", 32'h1, 32'(led_l));
      end
    end
    bus(1'b1, A_CTL, 32'h00000020);
    act <= 1'b1;
    settle(1);
    act <= 1'b0;
    settle(100);
    check("stretched led", 32'h1, 32'(led_a));
    bus(1'b1, A_CTL, 32'h000000A0);
    settle(3);
    check("bypassed led", 32'h0, 32'(led_a));
    bus(1'b1, A_CTL, 32'h00000000);
    act <= 1'b1;
    n = 0;
    repeat (4200) begin
      @(posedge sys_clk);
      if (led_l === 1'b0)
        n++;
    end
    check("link blink", 32'h1, 32'(n > 0));
    check("link lit", 32'h1, 32'(n < 4200));
    act <= 1'b0;
    ce <= 1'b0;
    spd <= 1'b0;
    settle(3);
    check("frozen speed led", 32'h1, 32'(led_s));
    check("stalled ready", 32'h0, 32'(hreadyout));
    ce <= 1'b1;
    settle(2);
    check("speed led resumes", 32'h0, 32'(led_s));
    $display("test led done");
    summarize();
  end
endmodule // test_phy_control_register
